/* shared/touch_ctrl_pkg.sv */
package touch_ctrl_pkg;

	// control word layout
	localparam int             WORD_W        = 8;
	localparam int             START_BIT     = 7;
	localparam int             CHAN_HI       = 6;
	localparam int             CHAN_LO       = 4;
	localparam int             MODE_BIT      = 3;
	localparam int             SER_BIT       = 2;
	localparam int             PD_HI_BIT     = 1;
	localparam int             PD_LO_BIT     = 0;
	localparam logic [7:0]     WORD_RESET    = 8'h02;

	// power field codes
	localparam logic [1:0]     PD_ADC_ON     = 2'h1;
	localparam logic [1:0]     PD_ALWAYS_ON  = 2'h3;

	// serial clock edge counts, counted from the start flag
	localparam logic [4:0]     CNT_ZERO          = 5'h00;
	localparam logic [4:0]     CNT_ONE           = 5'h01;
	localparam logic [4:0]     CNT_MAX           = 5'h1F;
	localparam logic [4:0]     LAST_BIT_RISE     = 5'h07;
	localparam logic [4:0]     IRQ_RELEASE_FALL  = 5'h04;
	localparam logic [4:0]     CONV_END_FALL_12  = 5'h14;
	localparam logic [4:0]     CONV_END_FALL_8   = 5'h10;
	localparam logic [4:0]     START_SPACING_12  = 5'h0F;
	localparam logic [4:0]     START_SPACING_8   = 5'h0B;

	// pin synchroniser bit positions and idle levels
	localparam int             PIN_SCLK      = 0;
	localparam int             PIN_CS_N      = 1;
	localparam int             PIN_DIN       = 2;
	localparam int             PIN_TOUCH     = 3;
	localparam logic [3:0]     PIN_IDLE      = 4'h2;

	typedef enum logic [1:0] {
		ST_HUNT    = 2'b00,
		ST_SHIFT   = 2'b01,
		ST_CONVERT = 2'b10
	} seq_state_e;

endpackage

/* shared/link_events_if.sv */
`timescale 1ns/1ps
interface link_events_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_low;
	logic cs_rise;
	logic din;
	logic touched;

	modport src (
		output sclk_rise,
		output sclk_fall,
		output cs_low,
		output cs_rise,
		output din,
		output touched
	);

	modport dst (
		input  sclk_rise,
		input  sclk_fall,
		input  cs_low,
		input  cs_rise,
		input  din,
		input  touched
	);
endinterface

/* design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
	import touch_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// pins
	input  wire logic       serial_shift_clock,
	input  wire logic       chip_select_n,
	input  wire logic       serial_data_in,
	input  wire logic       touch_sense,
	// events toward the core
	link_events_if.src      ev
);
	logic [3:0] meta;
	logic [3:0] stable;
	logic [3:0] stable_d;

	// two-stage synchroniser, then one history stage for edges
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta     <= PIN_IDLE;
			stable   <= PIN_IDLE;
			stable_d <= PIN_IDLE;
		end else begin
			meta     <= {touch_sense, serial_data_in, chip_select_n, serial_shift_clock};
			stable   <= meta;
			stable_d <= stable;
		end
	end

	assign ev.sclk_rise = stable[PIN_SCLK] & ~stable_d[PIN_SCLK];
	assign ev.sclk_fall = ~stable[PIN_SCLK] & stable_d[PIN_SCLK];
	assign ev.cs_low    = ~stable[PIN_CS_N];
	assign ev.cs_rise   = stable[PIN_CS_N] & ~stable_d[PIN_CS_N];
	assign ev.din       = stable[PIN_DIN];
	assign ev.touched   = stable[PIN_TOUCH];
endmodule

/* design/power_ctrl.sv */
`timescale 1ns/1ps
module power_ctrl
	import touch_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// power field and conversion state
	input  wire logic [1:0] power_field,
	input  wire logic       adc_converting,
	// power controls
	output logic            ref_power_on,
	output logic            adc_power_on
);
	// reference follows the upper field bit alone
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ref_power_on <= WORD_RESET[PD_HI_BIT];
		end else begin
			ref_power_on <= power_field[1];
		end
	end

	// converter on permanently, or only while converting
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			adc_power_on <= 1'b0;
		end else begin
			adc_power_on <= power_field[0] | adc_converting;
		end
	end
endmodule

/* design/touch_ctrl_word_pen_irq.sv */
`timescale 1ns/1ps
// Overview of operation
// - touch interrupt is open drain, only pulls low or releases.
// - enabled and touched, the interrupt pin is pulled low.
// - interrupt may stay enabled while powered down between conversions.
// - interrupt function is enabled after power-up, before any word.
// - a recognised start flag disables the interrupt function at once.
// - asserted interrupt held low until fourth falling clock after start, then released.
// - release at the fourth falling edge does not re-enable the function.
// - new power field enables the interrupt only at conversion end or a chip select rise between start flag and conversion end.
// - interrupt pin idles high whenever not asserted.
// - overlapped words bring a start before conversion end, keeping interrupt off.
// - host starts each word with a 1; device ignores input until then.
// - eight-bit word, msb first, first high bit is the start flag bit 7.
// - new word may start every 15th cycle (12-bit) or 11th (8-bit).
// - bits 6 to 4 form the channel address.
// - bit 3 selects resolution: 0 twelve bits, 1 eight bits.
// - bit 2 selects reference: 1 single-ended, 0 differential.
// - bits 1 and 0 are the power field, reset to upper 1, lower 0.
// - reference power is controlled independently of converter power.
// - power field 11 keeps everything on and the interrupt disabled.
// - field 00 powers converter down at conversion end or chip select rise.
// - word loads bit by bit during the first eight serial clocks.
module touch_ctrl_word_pen_irq
	import touch_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset,
	// serial link pins
	input  wire logic                serial_shift_clock,
	input  wire logic                chip_select_n,
	input  wire logic                serial_data_in,
	// touch sense from the screen comparator
	input  wire logic                touch_sense,
	// open-drain touch interrupt
	output logic                     touch_irq_n_out,
	output logic                     touch_irq_n_oe,
	// decoded control word
	output logic [touch_ctrl_pkg::WORD_W-1:0] conversion_control_word,
	output logic [2:0]               channel_select,
	output logic                     conv_8bit_sel,
	output logic                     ref_single_ended_sel,
	output logic                     power_cfg_hi,
	output logic                     power_cfg_lo,
	// power and conversion status
	output logic                     ref_power_on,
	output logic                     adc_power_on,
	output logic                     conversion_active,
	output logic                     conversion_done,
	output logic                     start_seen,
	output logic                     touch_irq_enabled
);
	import touch_ctrl_pkg::*;

	link_events_if ev ();

	seq_state_e              state;
	logic [WORD_W-1:0]       word;
	logic [4:0]              rise_cnt;
	logic [4:0]              fall_cnt;
	logic                    irq_enable;
	logic                    irq_hold;
	logic                    adc_converting;
	logic                    pulling;
	logic                    hunt_open;
	logic                    start_hit;
	logic                    rise_in_frame;
	logic                    fall_in_frame;
	logic                    release_now;
	logic                    conv_end_now;
	logic                    frame_abort;
	logic                    irq_after_conv;
	logic [4:0]              next_rise_cnt;
	logic [4:0]              next_fall_cnt;

	// rising count, this edge included, at which a new start may first be taken
	function automatic logic [4:0] start_gap(input logic eight_bit);
		start_gap = eight_bit ? (START_SPACING_8 - CNT_ONE) : (START_SPACING_12 - CNT_ONE);
	endfunction

	// falling edge count at which the conversion ends
	function automatic logic [4:0] conv_end(input logic eight_bit);
		conv_end = eight_bit ? CONV_END_FALL_8 : CONV_END_FALL_12;
	endfunction

	// saturating edge counter step
	function automatic logic [4:0] count_up(input logic [4:0] cnt);
		count_up = (cnt == CNT_MAX) ? CNT_MAX : cnt + CNT_ONE;
	endfunction

	// bit position written by a given rising count
	function automatic logic [2:0] bit_pos(input logic [4:0] cnt);
		bit_pos = 3'(LAST_BIT_RISE - cnt);
	endfunction

	pin_sync u_pin_sync (
		.ref_clk            (ref_clk),
		.reset              (reset),
		.serial_shift_clock (serial_shift_clock),
		.chip_select_n      (chip_select_n),
		.serial_data_in     (serial_data_in),
		.touch_sense        (touch_sense),
		.ev                 (ev.src)
	);

	power_ctrl u_power_ctrl (
		.ref_clk            (ref_clk),
		.reset              (reset),
		.power_field        (word[PD_HI_BIT:PD_LO_BIT]),
		.adc_converting     (adc_converting),
		.ref_power_on       (ref_power_on),
		.adc_power_on       (adc_power_on)
	);

	// edge qualification
	assign rise_in_frame = ev.sclk_rise & ev.cs_low;
	assign fall_in_frame = ev.sclk_fall & ev.cs_low & (state != ST_HUNT);
	assign next_rise_cnt = count_up(rise_cnt);
	assign next_fall_cnt = count_up(fall_cnt);

	// start hunting: idle, or late enough in a conversion for overlap
	always_comb begin
		hunt_open = 1'b0;
		case (state)
			ST_HUNT:    hunt_open = 1'b1;
			ST_CONVERT: hunt_open = (next_rise_cnt >= start_gap(word[MODE_BIT]));
			default:    hunt_open = 1'b0;
		endcase
	end

	// first high bit while hunting is the start flag
	assign start_hit = rise_in_frame & ev.din & hunt_open;

	assign release_now  = fall_in_frame & (next_fall_cnt == IRQ_RELEASE_FALL);
	assign conv_end_now = (state == ST_CONVERT) & fall_in_frame & ~start_hit
		& (next_fall_cnt == conv_end(word[MODE_BIT]));
	assign frame_abort  = ev.cs_rise & (state != ST_HUNT);
	assign irq_after_conv = (word[PD_HI_BIT:PD_LO_BIT] != PD_ALWAYS_ON);

	// word sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= ST_HUNT;
		end else if (ev.cs_rise) begin
			state <= ST_HUNT;
		end else if (start_hit) begin
			state <= ST_SHIFT;
		end else begin
			case (state)
				ST_HUNT: begin
					state <= ST_HUNT;
				end
				ST_SHIFT: begin
					if (rise_in_frame && next_rise_cnt == LAST_BIT_RISE) begin
						state <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (conv_end_now) begin
						state <= ST_HUNT;
					end
				end
				default: begin
					state <= ST_HUNT;
				end
			endcase
		end
	end

	// rising edges since the start flag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rise_cnt <= CNT_ZERO;
		end else if (ev.cs_rise) begin
			rise_cnt <= CNT_ZERO;
		end else if (start_hit) begin
			rise_cnt <= CNT_ZERO;
		end else if (rise_in_frame && state != ST_HUNT) begin
			rise_cnt <= next_rise_cnt;
		end
	end

	// falling edges since the start flag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fall_cnt <= CNT_ZERO;
		end else if (ev.cs_rise) begin
			fall_cnt <= CNT_ZERO;
		end else if (start_hit) begin
			fall_cnt <= CNT_ZERO;
		end else if (fall_in_frame) begin
			fall_cnt <= next_fall_cnt;
		end
	end

	// control word, updated as each bit arrives
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			word <= WORD_RESET;
		end else if (start_hit) begin
			word[START_BIT] <= 1'b1;
		end else if (state == ST_SHIFT && rise_in_frame) begin
			word[bit_pos(next_rise_cnt)] <= ev.din;
		end
	end

	// converter runs from the fourth falling edge to conversion end, the next start flag or a chip select rise
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			adc_converting <= 1'b0;
		end else if (ev.cs_rise || conv_end_now || start_hit) begin
			adc_converting <= 1'b0;
		end else if (release_now) begin
			adc_converting <= 1'b1;
		end
	end

	// interrupt function enable
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_enable <= 1'b1;
		end else if (start_hit) begin
			irq_enable <= 1'b0;
		end else if (conv_end_now || frame_abort) begin
			irq_enable <= irq_after_conv;
		end
	end

	// an asserted interrupt is held past the start flag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_hold <= 1'b0;
		end else if (start_hit) begin
			irq_hold <= pulling;
		end else if (release_now || ev.cs_rise) begin
			irq_hold <= 1'b0;
		end
	end

	assign pulling = (irq_enable & ev.touched) | irq_hold;

	// open-drain pin: output level fixed low, enable pulls
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			touch_irq_n_out <= 1'b0;
			touch_irq_n_oe  <= 1'b0;
		end else begin
			touch_irq_n_out <= 1'b0;
			touch_irq_n_oe  <= pulling;
		end
	end

	// decoded fields
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			conversion_control_word <= WORD_RESET;
			channel_select          <= WORD_RESET[CHAN_HI:CHAN_LO];
			conv_8bit_sel           <= WORD_RESET[MODE_BIT];
			ref_single_ended_sel    <= WORD_RESET[SER_BIT];
			power_cfg_hi            <= WORD_RESET[PD_HI_BIT];
			power_cfg_lo            <= WORD_RESET[PD_LO_BIT];
		end else begin
			conversion_control_word <= word;
			channel_select          <= word[CHAN_HI:CHAN_LO];
			conv_8bit_sel           <= word[MODE_BIT];
			ref_single_ended_sel    <= word[SER_BIT];
			power_cfg_hi            <= word[PD_HI_BIT];
			power_cfg_lo            <= word[PD_LO_BIT];
		end
	end

	// status outputs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			conversion_active <= 1'b0;
			conversion_done   <= 1'b0;
			start_seen        <= 1'b0;
			touch_irq_enabled <= 1'b1;
		end else begin
			conversion_active <= adc_converting;
			conversion_done   <= conv_end_now;
			start_seen        <= start_hit;
			touch_irq_enabled <= irq_enable;
		end
	end
endmodule

/* testbench/touch_ctrl_word_pen_irq_chk.sv */
`timescale 1ns/1ps
module touch_ctrl_word_pen_irq_chk
	import touch_ctrl_pkg::*;
(
	// clock and reset
	input wire logic                                ref_clk,
	input wire logic                                reset,
	// watched pins
	input wire logic                                chip_select_n,
	input wire logic                                touch_sense,
	input wire logic                                touch_irq_n_out,
	input wire logic                                touch_irq_n_oe,
	// watched word and status
	input wire logic [touch_ctrl_pkg::WORD_W-1:0]   conversion_control_word,
	input wire logic [2:0]                          channel_select,
	input wire logic                                conv_8bit_sel,
	input wire logic                                ref_single_ended_sel,
	input wire logic                                power_cfg_hi,
	input wire logic                                power_cfg_lo,
	input wire logic                                ref_power_on,
	input wire logic                                adc_power_on,
	input wire logic                                conversion_active,
	input wire logic                                conversion_done,
	input wire logic                                start_seen,
	input wire logic                                touch_irq_enabled
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_touch_held;
		(touch_irq_enabled && touch_sense) [*6];
	endsequence
	sequence s_word_settled;
		$stable(conversion_control_word) [*2];
	endsequence
	drain_only_a: assert property (touch_irq_n_out == 1'b0)
		else $error("interrupt data not low");
	touch_pull_a: assert property (s_touch_held |-> touch_irq_n_oe)
		else $error("touch not signalled");
	pull_cause_a: assert property ($rose(touch_irq_n_oe) |-> touch_irq_enabled)
		else $error("interrupt pulled while disabled");
	start_off_a: assert property (start_seen |=> !touch_irq_enabled)
		else $error("start did not disable interrupt");
	release_a: assert property ($rose(conversion_active) |-> ##[0:8] !touch_irq_n_oe)
		else $error("interrupt not released");
	enable_cause_a: assert property ($rose(touch_irq_enabled) |->
		conversion_done || $past(conversion_done) || chip_select_n)
		else $error("interrupt enabled mid conversion");
	enable_field_a: assert property ($rose(touch_irq_enabled) |->
		{power_cfg_hi, power_cfg_lo} != PD_ALWAYS_ON)
		else $error("interrupt enabled with field 11");
	start_bit_a: assert property (start_seen |-> ##[0:2] conversion_control_word[START_BIT])
		else $error("start bit not stored");
	field_decode_a: assert property (s_word_settled |-> channel_select == conversion_control_word[6:4] &&
		conv_8bit_sel == conversion_control_word[3] && ref_single_ended_sel == conversion_control_word[2] &&
		{power_cfg_hi, power_cfg_lo} == conversion_control_word[1:0])
		else $error("field decode wrong");
	ref_power_a: assert property ($stable(power_cfg_hi) [*2] |-> ref_power_on == power_cfg_hi)
		else $error("reference power wrong");
	adc_power_a: assert property (conversion_active [*2] |-> adc_power_on)
		else $error("converter off while converting");
endmodule
bind touch_ctrl_word_pen_irq touch_ctrl_word_pen_irq_chk u_chk (.ref_clk(ref_clk), .reset(reset),
	.chip_select_n(chip_select_n), .touch_sense(touch_sense), .touch_irq_n_out(touch_irq_n_out),
	.touch_irq_n_oe(touch_irq_n_oe), .conversion_control_word(conversion_control_word),
	.channel_select(channel_select), .conv_8bit_sel(conv_8bit_sel), .ref_single_ended_sel(ref_single_ended_sel),
	.power_cfg_hi(power_cfg_hi), .power_cfg_lo(power_cfg_lo), .ref_power_on(ref_power_on),
	.adc_power_on(adc_power_on), .conversion_active(conversion_active), .conversion_done(conversion_done),
	.start_seen(start_seen), .touch_irq_enabled(touch_irq_enabled));

/* testbench/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
	// commands from the bench
	input wire logic        go,
	input wire logic [7:0]  word,
	input wire logic [7:0]  word2,
	input wire logic [3:0]  lead,
	input wire logic [4:0]  gap,
	input wire logic [5:0]  nclk,
	// serial pins and busy flag
	output logic            serial_shift_clock,
	output logic            chip_select_n,
	output logic            serial_data_in,
	output logic            busy
);
	int k;
	function automatic logic bit_at(int n);
		if (n >= lead && n < lead + 8)
			return word[7 + lead - n];
		if (gap != 0 && n >= lead + gap && n < lead + gap + 8)
			return word2[7 + lead + gap - n];
		return 1'b0;
	endfunction
	initial begin
		serial_shift_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
		busy = 1'b0;
	end
	// idle data line carries no value
	always #24 if (!busy) serial_data_in = ~serial_data_in;
	always @(posedge go) begin
		busy = 1'b1;
		chip_select_n = 1'b0;
		for (k = 0; k < nclk; k++) begin
			serial_data_in = bit_at(k);
			#24 serial_shift_clock = 1'b1;
			#24 serial_shift_clock = 1'b0;
		end
		#24 chip_select_n = 1'b1;
		busy = 1'b0;
	end
endmodule

/* testbench/touch_ctrl_word_pen_irq_tb.sv */
`timescale 1ns/1ps
module touch_ctrl_word_pen_irq_tb;
	import touch_ctrl_pkg::*;
	logic        ref_clk, reset, touch_sense, go, sclk, cs_n, din, busy, oe, out_n, pen;
	logic        m8, ser, pdh, pdl, refp, adcp, act, done, st, en;
	logic [7:0]  word, word2, cw;
	logic [7:0]  corner [3] = '{8'hFF, 8'h80, 8'hB6};
	logic [3:0]  lead;
	logic [4:0]  gap;
	logic [5:0]  nclk;
	logic [2:0]  chan;
	int          n_mismatch, checks, ns, ta, ts, it;
	always #2.5 ref_clk = ~ref_clk;
	touch_ctrl_word_pen_irq dut (.ref_clk(ref_clk), .reset(reset), .serial_shift_clock(sclk), .chip_select_n(cs_n),
		.serial_data_in(din), .touch_sense(touch_sense), .touch_irq_n_out(out_n), .touch_irq_n_oe(oe),
		.conversion_control_word(cw), .channel_select(chan), .conv_8bit_sel(m8), .ref_single_ended_sel(ser),
		.power_cfg_hi(pdh), .power_cfg_lo(pdl), .ref_power_on(refp), .adc_power_on(adcp),
		.conversion_active(act), .conversion_done(done), .start_seen(st), .touch_irq_enabled(en));
	serial_host_model host (.go(go), .word(word), .word2(word2), .lead(lead), .gap(gap), .nclk(nclk),
		.serial_shift_clock(sclk), .chip_select_n(cs_n), .serial_data_in(din), .busy(busy));
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// a position channel that may use differential referencing
	localparam logic [2:0] DIFF_CHAN = 3'h1;
	function automatic logic [7:0] host_word(logic [6:0] r);
		return {1'b1, (r[2] ? r[6:4] : DIFF_CHAN), r[3:0]};
	endfunction
	function automatic logic exp_en(logic [7:0] v);
		return v[1:0] != PD_ALWAYS_ON;
	endfunction
	task automatic final_report;
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic frame(logic t);
		logic [7:0] e;
		e = (gap != 0) ? word2 : word;
		touch_sense = t;
		repeat (6) @(negedge ref_clk);
		chk(oe, pen & t);
		go = 1'b1;
		ns = 0;
		ta = -99;
		ts = -99;
		for (it = 0; it < 1000 && (busy || it < 4); it++) begin
			@(negedge ref_clk);
			go = 1'b0;
			if (st) begin
				ns++;
				ts = it;
			end
			if (it == ts + 2) chk(en, 0);
			if (act && ta < 0) begin
				ta = it;
				chk(en, 0);
			end
			if (it == ta + 8) chk(oe, 0);
		end
		if (it >= 1000) begin
			n_mismatch++;
			final_report();
		end
		repeat (6) @(negedge ref_clk);
		chk(8'(ns), (gap != 0) ? 8'h02 : 8'h01);
		chk(cw, e);
		chk(chan, e[6:4]);
		chk(m8, e[3]);
		chk(ser, e[2]);
		chk({pdh, pdl}, e[1:0]);
		chk(refp, e[1]);
		chk(adcp, e[0]);
		chk(en, exp_en(e));
		chk(oe, exp_en(e) & t);
		chk(out_n, 0);
		pen = exp_en(e);
	endtask
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		touch_sense = 1'b0;
		go = 1'b0;
		word = 8'h00;
		word2 = 8'h00;
		lead = 4'h0;
		gap = 5'h00;
		nclk = 6'h00;
		void'($urandom(98774));
		repeat (5) @(negedge ref_clk);
		reset = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(cw, WORD_RESET);
		chk(en, 1);
		chk(refp, 1);
		pen = 1'b1;
		for (int i = 0; i < 14; i++) begin
			word = host_word((i < 3) ? corner[i][6:0] : 7'($urandom()));
			word2 = host_word(7'($urandom()));
			lead = 4'($urandom_range(5));
			gap = ($urandom_range(2) == 0) ? 5'(word[3] ? START_SPACING_8 - 1 : START_SPACING_12 - 1) : 5'h00;
			nclk = (gap != 0) ? 6'(lead + gap + 24) : 6'(lead + ($urandom_range(1) ? 24 : 12));
			frame(1'($urandom()) | (i < 3));
		end
		final_report();
	end
endmodule
